// >>> hdl/pressure_status_pkg.sv
`default_nettype none

package pressure_status_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register offsets on the serial register port
    localparam logic [7:0] INTERRUPT_SOURCE_ADDR        = 8'h25;
    localparam logic [7:0] FIFO_FILL_STATUS_ADDR        = 8'h26;
    localparam logic [7:0] DATA_STATUS_ADDR             = 8'h27;
    localparam logic [7:0] PRESSURE_RESULT_LOW_ADDR     = 8'h28;
    localparam logic [7:0] PRESSURE_RESULT_MID_ADDR     = 8'h29;
    localparam logic [7:0] PRESSURE_RESULT_HIGH_ADDR    = 8'h2A;
    localparam logic [7:0] TEMPERATURE_RESULT_LOW_ADDR  = 8'h2B;
    localparam logic [7:0] TEMPERATURE_RESULT_HIGH_ADDR = 8'h2C;
    localparam logic [7:0] LOWPASS_FILTER_RESET_ADDR    = 8'h33;

    ////////////////////////////////////////////////////////////////////////
    // field positions, interrupt_source
    localparam int BOOT_ACTIVE_BIT         = 7;
    localparam int INTERRUPT_ACTIVE_BIT    = 2;
    localparam int PRESSURE_LOW_EVENT_BIT  = 1;
    localparam int PRESSURE_HIGH_EVENT_BIT = 0;

    // field positions, fifo_fill_status
    localparam int FIFO_WATERMARK_REACHED_BIT = 7;
    localparam int FIFO_OVERRUN_BIT           = 6;
    localparam int FIFO_FILL_LEVEL_WIDTH      = 6;

    // field positions, data_status
    localparam int TEMPERATURE_OVERRUN_BIT   = 5;
    localparam int PRESSURE_OVERRUN_BIT      = 4;
    localparam int TEMPERATURE_AVAILABLE_BIT = 1;
    localparam int PRESSURE_AVAILABLE_BIT    = 0;

    ////////////////////////////////////////////////////////////////////////
    // widths, levels and reset values
    localparam int WATERMARK_LEVEL_WIDTH    = 5;
    localparam int PRESSURE_WIDTH           = 24;
    localparam int TEMPERATURE_WIDTH        = 16;
    localparam int TRIM_WIDTH               = 16;
    localparam int TRIM_SCALE_SHIFT         = 8;  // trim weighted by 256

    localparam logic [5:0]  FIFO_FULL_LEVEL        = 6'h20;  // 32 samples
    localparam logic [7:0]  REGISTER_RESET         = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ_VALUE    = 8'h00;
    localparam logic [23:0] PRESSURE_RESULT_RESET  = 24'h00_0000;
    localparam logic [15:0] TEMPERATURE_RESULT_RESET = 16'h0000;

endpackage

`default_nettype wire

// >>> hdl/pressure_offset_trim.sv
`default_nettype none

// subtracts the scaled offset trim from the raw pressure word unless differential, auto-zero or auto-reference is on
module pressure_offset_trim (
    input  wire logic [23:0] rawPressure,
    input  wire logic [15:0] pressureOffsetTrim,
    input  wire logic        differentialEnable,
    input  wire logic        autoZeroEnable,
    input  wire logic        autoReferenceEnable,
    output logic      [23:0] trimmedPressure
);

    logic [23:0] scaledTrim;
    logic        trimApplies;

    // trim times 256 fills the upper two bytes, wraps in two's complement
    assign scaledTrim = {pressureOffsetTrim,
                         8'h00};
    // other reference modes are handled upstream, pass raw through then
    assign trimApplies = !differentialEnable && !autoZeroEnable
                         && !autoReferenceEnable;
    assign trimmedPressure = trimApplies ? (rawPressure - scaledTrim)
                                         : rawPressure;

endmodule

`default_nettype wire

// >>> hdl/pressure_status_regs.sv
`default_nettype none

// Functional notes
// - boot flag high while boot runs
// - interrupt active once any enabled event fires
// - low pressure event flag latched
// - high pressure event flag latched
// - watermark flag when fill reaches watermark
// - overrun flag when full sample overwritten
// - six-bit fill count, 32 means full
// - temperature overrun on unread overwrite
// - pressure overrun on unread overwrite
// - temperature available on new result
// - pressure available on new result
// - data status view refreshed each rate tick
// - pressure bytes low to high addresses
// - pressure equals raw minus offset trim, raw when a reference mode is on
// - trim scaled by 256 before subtract
// - temperature bytes low then high
// - reading filter reset register resets filter, only while the lowpass filter is on
module pressure_status_regs (
    input  wire logic        clk,
    input  wire logic        nrst,
    // register read port from the serial interface
    input  wire logic        readStrobe,
    input  wire logic [7:0]  readAddr,
    output logic      [7:0]  readData,
    // core status inputs
    input  wire logic        bootActive,
    input  wire logic        pressureLowHit,
    input  wire logic        pressureHighHit,
    input  wire logic        otherInterruptHit,
    input  wire logic [5:0]  fifoFillLevel,
    input  wire logic        fifoOverwrite,
    input  wire logic [4:0]  watermarkLevel,
    // measurement inputs
    input  wire logic        outputDataRateTick,
    input  wire logic        pressureNew,
    input  wire logic [23:0] rawPressure,
    input  wire logic        temperatureNew,
    input  wire logic [15:0] rawTemperature,
    input  wire logic [15:0] pressureOffsetTrim,
    input  wire logic        differentialEnable,
    input  wire logic        autoZeroEnable,
    input  wire logic        autoReferenceEnable,
    input  wire logic        pressureLowpassFilter,
    // outputs to the core
    output logic             lowpassFilterReset,
    output logic             interruptActive
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [7:0]  readData;
        logic        filterReset;
        logic        bootFlag;
        logic        intActive;
        logic        lowEvent;
        logic        highEvent;
        logic        watermarkReached;
        logic        fifoOverrun;
        logic [5:0]  fillLevel;
        logic        tempAvail;
        logic        pressAvail;
        logic        tempOverrun;
        logic        pressOverrun;
        logic [7:0]  statusView;
        logic [23:0] pressureResult;
        logic [15:0] temperatureResult;
    } state_t;

    state_t      state;
    state_t      next_state;
    logic [23:0] trimmedPressure;

    // true when the host reads the given offset this cycle
    function automatic logic readOf(input logic [7:0] addr,
                                    input logic       strobe,
                                    input logic [7:0] target);
        readOf = strobe && (addr == target);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // flag and byte helpers

    // sticky flag: a hit in the clearing cycle still wins
    function automatic logic stickyNext(input logic hit,
                                        input logic held,
                                        input logic clear);
        stickyNext = hit || (held && !clear);
    endfunction

    // overrun when an unread result is replaced; a read in the same
    // cycle counts as taken, so the fresh sample starts clean
    function automatic logic overrunNext(input logic avail,
                                         input logic overrun,
                                         input logic taken);
        overrunNext = (avail || overrun) && !taken;
    endfunction

    // at-or-above compare; the host field is one bit short of the count
    function automatic logic atWatermark(input logic [5:0] level,
                                         input logic [4:0] watermark);
        atWatermark = level >= {1'b0, watermark};
    endfunction

    // full with an overwrite; drops as soon as the fifo is not full
    function automatic logic fifoOverrunNext(input logic [5:0] level,
                                             input logic       overwrite,
                                             input logic       held);
        fifoOverrunNext = (level == pressure_status_pkg::FIFO_FULL_LEVEL)
                          && (overwrite || held);
    endfunction

    // interrupt source byte, bits 6 to 3 reserved and read zero
    function automatic logic [7:0] intSourceByte(input logic boot,
                                                 input logic active,
                                                 input logic low,
                                                 input logic high);
        intSourceByte = pressure_status_pkg::REGISTER_RESET;
        intSourceByte[pressure_status_pkg::BOOT_ACTIVE_BIT] = boot;
        intSourceByte[pressure_status_pkg::INTERRUPT_ACTIVE_BIT] = active;
        intSourceByte[pressure_status_pkg::PRESSURE_LOW_EVENT_BIT] = low;
        intSourceByte[pressure_status_pkg::PRESSURE_HIGH_EVENT_BIT] = high;
    endfunction

    // fifo status byte: threshold, overrun, then the six-bit fill count
    function automatic logic [7:0] fifoStatusByte(input logic       threshold,
                                                  input logic       overrun,
                                                  input logic [5:0] level);
        fifoStatusByte = pressure_status_pkg::REGISTER_RESET;
        fifoStatusByte[pressure_status_pkg::FIFO_WATERMARK_REACHED_BIT] =
            threshold;
        fifoStatusByte[pressure_status_pkg::FIFO_OVERRUN_BIT] = overrun;
        fifoStatusByte[5:0] = level;
    endfunction

    // data status byte; bits 7, 6, 3 and 2 are reserved and read zero
    function automatic logic [7:0] dataStatusByte(input logic tOver,
                                                  input logic pOver,
                                                  input logic tAv,
                                                  input logic pAv);
        dataStatusByte = pressure_status_pkg::REGISTER_RESET;
        dataStatusByte[pressure_status_pkg::TEMPERATURE_OVERRUN_BIT] = tOver;
        dataStatusByte[pressure_status_pkg::PRESSURE_OVERRUN_BIT] = pOver;
        dataStatusByte[pressure_status_pkg::TEMPERATURE_AVAILABLE_BIT] = tAv;
        dataStatusByte[pressure_status_pkg::PRESSURE_AVAILABLE_BIT] = pAv;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // offset trim path

    pressure_offset_trim trimUnit (
        .rawPressure         (rawPressure),
        .pressureOffsetTrim  (pressureOffsetTrim),
        .differentialEnable  (differentialEnable),
        .autoZeroEnable      (autoZeroEnable),
        .autoReferenceEnable (autoReferenceEnable),
        .trimmedPressure     (trimmedPressure)
    );

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        logic        intRead;
        logic        pressRead;
        logic        tempRead;
        logic [7:0]  intByte;
        logic [7:0]  fifoByte;
        logic [7:0]  liveStatus;
        intRead   = readOf(readAddr, readStrobe,
                           pressure_status_pkg::INTERRUPT_SOURCE_ADDR);
        // msb read closes a pressure or temperature read sequence
        pressRead = readOf(readAddr, readStrobe,
                           pressure_status_pkg::PRESSURE_RESULT_HIGH_ADDR);
        tempRead  = readOf(readAddr, readStrobe,
                           pressure_status_pkg::TEMPERATURE_RESULT_HIGH_ADDR);
        intByte    = pressure_status_pkg::REGISTER_RESET;
        fifoByte   = pressure_status_pkg::REGISTER_RESET;
        liveStatus = pressure_status_pkg::REGISTER_RESET;
        next_state = state;

        // boot flag simply follows the core
        next_state.bootFlag = bootActive;

        // sticky event flags: a new hit wins over the read-clear
        next_state.lowEvent =
            stickyNext(pressureLowHit, state.lowEvent, intRead);
        next_state.highEvent =
            stickyNext(pressureHighHit, state.highEvent, intRead);
        next_state.intActive = stickyNext(
            pressureLowHit || pressureHighHit || otherInterruptHit,
            state.intActive, intRead);

        // fifo status mirrors the fill count every cycle
        next_state.fillLevel = fifoFillLevel;
        // watermark field comes from the host-set control register
        next_state.watermarkReached =
            atWatermark(fifoFillLevel, watermarkLevel);
        // overrun holds until the fifo drains below full
        next_state.fifoOverrun = fifoOverrunNext(fifoFillLevel,
            fifoOverwrite, state.fifoOverrun);

        // result capture; overrun when the old one was never read
        if (pressureNew) begin
            next_state.pressureResult = trimmedPressure;
            next_state.pressAvail     = 1'b1;
            next_state.pressOverrun   = overrunNext(state.pressAvail,
                state.pressOverrun, pressRead);
        end else if (pressRead) begin
            next_state.pressAvail   = 1'b0;
            next_state.pressOverrun = 1'b0;
        end
        if (temperatureNew) begin
            next_state.temperatureResult = rawTemperature;
            next_state.tempAvail         = 1'b1;
            next_state.tempOverrun       = overrunNext(state.tempAvail,
                state.tempOverrun, tempRead);
        end else if (tempRead) begin
            next_state.tempAvail   = 1'b0;
            next_state.tempOverrun = 1'b0;
        end

        // the visible status byte only moves on the rate tick
        liveStatus = dataStatusByte(next_state.tempOverrun,
                                    next_state.pressOverrun,
                                    next_state.tempAvail,
                                    next_state.pressAvail);
        if (outputDataRateTick) begin
            next_state.statusView = liveStatus;
        end

        // filter reset is a one-cycle pulse, only with the filter on
        next_state.filterReset = pressureLowpassFilter
            && readOf(readAddr, readStrobe,
                      pressure_status_pkg::LOWPASS_FILTER_RESET_ADDR);

        // read data assembly, reserved bits read zero
        intByte  = intSourceByte(state.bootFlag, state.intActive,
                                 state.lowEvent, state.highEvent);
        fifoByte = fifoStatusByte(state.watermarkReached,
                                  state.fifoOverrun, state.fillLevel);

        if (readStrobe) begin
            case (readAddr)
                pressure_status_pkg::INTERRUPT_SOURCE_ADDR: begin
                    next_state.readData = intByte;
                end
                pressure_status_pkg::FIFO_FILL_STATUS_ADDR: begin
                    next_state.readData = fifoByte;
                end
                pressure_status_pkg::DATA_STATUS_ADDR: begin
                    next_state.readData = state.statusView;
                end
                pressure_status_pkg::PRESSURE_RESULT_LOW_ADDR: begin
                    next_state.readData = state.pressureResult[7:0];
                end
                pressure_status_pkg::PRESSURE_RESULT_MID_ADDR: begin
                    next_state.readData = state.pressureResult[15:8];
                end
                pressure_status_pkg::PRESSURE_RESULT_HIGH_ADDR: begin
                    next_state.readData =
                        state.pressureResult[23:16];
                end
                pressure_status_pkg::TEMPERATURE_RESULT_LOW_ADDR: begin
                    next_state.readData =
                        state.temperatureResult[7:0];
                end
                pressure_status_pkg::TEMPERATURE_RESULT_HIGH_ADDR: begin
                    next_state.readData =
                        state.temperatureResult[15:8];
                end
                default: begin
                    next_state.readData =
                        pressure_status_pkg::UNMAPPED_READ_VALUE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from flops
    assign readData           = state.readData;
    assign lowpassFilterReset = state.filterReset;
    assign interruptActive    = state.intActive;

endmodule

`default_nettype wire

// >>> test/pressure_status_props.sv
`default_nettype none

// watches read answers, event flags and the filter reset pulse
module pressure_status_props (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       readStrobe,
    input wire logic [7:0] readAddr,
    input wire logic [7:0] readData,
    input wire logic       bootActive,
    input wire logic       pressureLowHit,
    input wire logic       pressureHighHit,
    input wire logic       otherInterruptHit,
    input wire logic [5:0] fifoFillLevel,
    input wire logic [4:0] watermarkLevel,
    input wire logic       pressureLowpassFilter,
    input wire logic       lowpassFilterReset,
    input wire logic       interruptActive
);
    timeunit 1ns;
    timeprecision 1ps;

    // decoded requests and event causes
    wire logic rdSrc   = readStrobe && readAddr == 8'h25;
    wire logic rdFifo  = readStrobe && readAddr == 8'h26;
    wire logic rdNone  = readStrobe && (readAddr < 8'h25 || readAddr > 8'h2C);
    wire logic filtHit = readStrobe && readAddr == 8'h33
                         && pressureLowpassFilter;
    wire logic anyHit  = pressureLowHit || pressureHighHit || otherInterruptHit;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////
    // a lone filter read must give exactly one pulse
    sequence filtLone;
        filtHit ##1 !filtHit;
    endsequence
    sequence oneShot;
        lowpassFilterReset ##1 !lowpassFilterReset;
    endsequence

    filter_pulse_a: assert property (filtLone |-> oneShot)
        else $error("filter reset pulse missing or too long");
    filter_cause_a: assert property (
        lowpassFilterReset |-> $past(filtHit))
        else $error("filter reset pulse without a read");
    ia_set_a: assert property (anyHit |=> interruptActive)
        else $error("interrupt active not set by event");
    ia_cause_a: assert property (
        $rose(interruptActive) |-> $past(anyHit))
        else $error("interrupt active rose with no event");
    ia_clear_a: assert property (
        rdSrc && !anyHit |=> !interruptActive)
        else $error("interrupt active not cleared by read");
    boot_flag_a: assert property (
        rdSrc |=> readData[7] == $past(bootActive, 2))
        else $error("boot flag does not follow boot phase");
    src_layout_a: assert property (
        rdSrc |=> readData[6:3] == 4'h0
            && readData[2] == $past(interruptActive))
        else $error("interrupt source layout wrong");
    fifo_level_a: assert property (
        rdFifo |=> readData[5:0] == $past(fifoFillLevel, 2))
        else $error("fill level field wrong");
    watermark_a: assert property (
        rdFifo |=> readData[7] == ($past(fifoFillLevel, 2)
            >= {1'b0, $past(watermarkLevel, 2)}))
        else $error("watermark flag wrong");
    unmapped_zero_a: assert property (rdNone |=> readData == 8'h00)
        else $error("unmapped read not zero");
endmodule

bind pressure_status_regs pressure_status_props props (
    .clk(clk), .nrst(nrst), .readStrobe(readStrobe),
    .readAddr(readAddr), .readData(readData), .bootActive(bootActive),
    .pressureLowHit(pressureLowHit), .pressureHighHit(pressureHighHit),
    .otherInterruptHit(otherInterruptHit),
    .fifoFillLevel(fifoFillLevel), .watermarkLevel(watermarkLevel),
    .pressureLowpassFilter(pressureLowpassFilter),
    .lowpassFilterReset(lowpassFilterReset),
    .interruptActive(interruptActive)
);

`default_nettype wire

// >>> test/host_reader.sv
`default_nettype none

// host side of the register port: strobed reads only, no writes
module host_reader (
    input  wire logic       clk,
    output logic            readStrobe,
    output logic      [7:0] readAddr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        readStrobe = 1'b0;
        readAddr   = 8'h00;
    end

    ////////////////////////////////////////////////////////////
    // one read held across the sampling edge; address scrambled after
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        readStrobe = 1'b1;
        readAddr   = a;
        @(negedge clk);
        readStrobe = 1'b0;
        readAddr   = ~a;  // stale address must not look valid
    endtask
endmodule

`default_nettype wire

// >>> test/test_pressure_status_regs.sv
`default_nettype none

module test_pressure_status_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, nrst, readStrobe, tookRead, bootActive;
    logic        pressureLowHit, pressureHighHit, otherInterruptHit;
    logic        fifoOverwrite, outputDataRateTick, pressureNew;
    logic        temperatureNew, differentialEnable, autoZeroEnable;
    logic        autoReferenceEnable, pressureLowpassFilter;
    logic        lowpassFilterReset, interruptActive;
    logic [4:0]  watermarkLevel;
    logic [5:0]  fifoFillLevel;
    logic [7:0]  readAddr, readData;
    logic [15:0] rawTemperature, pressureOffsetTrim;
    logic [23:0] rawPressure, expP;
    logic [7:0]  expQ[$];
    integer      seed;
    int          miscompares, check_count, cycles;

    pressure_status_regs dut (
        .clk, .nrst, .readStrobe, .readAddr, .readData, .bootActive,
        .pressureLowHit, .pressureHighHit, .otherInterruptHit,
        .fifoFillLevel, .fifoOverwrite, .watermarkLevel,
        .outputDataRateTick, .pressureNew, .rawPressure,
        .temperatureNew, .rawTemperature, .pressureOffsetTrim,
        .differentialEnable, .autoZeroEnable, .autoReferenceEnable,
        .pressureLowpassFilter, .lowpassFilterReset, .interruptActive
    );
    host_reader host (.clk, .readStrobe, .readAddr);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////
    // answer lands one edge after the strobe; compare oldest note
    always @(posedge clk) tookRead <= readStrobe;
    always @(negedge clk) begin
        cycles++;
        if (tookRead === 1'b1) begin
            check_count++;
            if (readData !== expQ[0]) begin
                miscompares++;
                $display("[ERR] %0t got %h exp %h", $time, readData, expQ[0]);
            end
            void'(expQ.pop_front());
        end
        if (cycles > 3000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (miscompares == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // note the expectation first, then let the host read
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        host.rd(a);
    endtask
    task automatic rdP(input logic [23:0] e);
        rd(8'h28, e[7:0]);
        rd(8'h29, e[15:8]);
        rd(8'h2A, e[23:16]);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h42ad_a99a;
        {nrst, bootActive, pressureLowHit, pressureHighHit,
         otherInterruptHit, fifoOverwrite, outputDataRateTick, pressureNew,
         temperatureNew, differentialEnable, autoZeroEnable,
         autoReferenceEnable, pressureLowpassFilter, watermarkLevel,
         fifoFillLevel, rawTemperature, pressureOffsetTrim, rawPressure} = '0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        rd(8'h25, 8'h00);
        bootActive = 1'b1;
        rd(8'h25, 8'h80);
        bootActive = 1'b0;
        // each event source, then a read-clear
        pulse(pressureLowHit);
        rd(8'h25, 8'h06);
        rd(8'h25, 8'h00);
        pulse(pressureHighHit);
        rd(8'h25, 8'h05);
        pulse(otherInterruptHit);
        rd(8'h25, 8'h04);
        // random fill against random watermark, then full and overwrite
        for (int i = 0; i < 12; i++) begin
            fifoFillLevel  = 6'($unsigned($random(seed)) % 33);
            watermarkLevel = 5'($random(seed));
            rd(8'h26, {fifoFillLevel >= 6'(watermarkLevel), 1'b0,
                       fifoFillLevel});
        end
        fifoFillLevel  = 6'h20;
        watermarkLevel = 5'h1f;
        rd(8'h26, 8'ha0);
        pulse(fifoOverwrite);
        rd(8'h26, 8'he0);
        fifoFillLevel = 6'h1f;
        rd(8'h26, 8'h9f);
        // trimmed result, then each mode enable passing raw through
        pressureOffsetTrim = 16'($random(seed));
        for (int m = 0; m < 4; m++) begin
            {differentialEnable, autoZeroEnable, autoReferenceEnable} =
                (m == 0) ? 3'b000 : 3'(3'b100 >> (m - 1));
            rawPressure = 24'($random(seed));
            expP = (m == 0) ? rawPressure - {pressureOffsetTrim, 8'h00}
                            : rawPressure;
            pulse(pressureNew);
            rdP(expP);
        end
        // two unread samples of each kind give overruns
        {differentialEnable, autoZeroEnable, autoReferenceEnable} = 3'b000;
        rawTemperature = 16'($random(seed));
        expP = rawPressure - {pressureOffsetTrim, 8'h00};
        pulse(pressureNew);
        pulse(temperatureNew);
        pulse(pressureNew);
        pulse(temperatureNew);
        pulse(outputDataRateTick);
        rd(8'h27, 8'h33);
        rdP(expP);
        rd(8'h2B, rawTemperature[7:0]);
        rd(8'h2C, rawTemperature[15:8]);
        rd(8'h27, 8'h33);
        pulse(outputDataRateTick);
        rd(8'h27, 8'h00);
        // filter reset read with filter on and off, one unmapped read
        pressureLowpassFilter = 1'b1;
        rd(8'h33, 8'h00);
        pressureLowpassFilter = 1'b0;
        rd(8'h33, 8'h00);
        rd(8'h30, 8'h00);
        repeat (2) @(negedge clk);
        end_sim();
    end
endmodule

`default_nettype wire
